// ===== shared/rtc_special_regs.svh
`ifndef RTC_SPECIAL_REGS_SVH
`define RTC_SPECIAL_REGS_SVH
`define ADDR_SECONDS        4'h0
`define ADDR_MINUTES        4'h1
`define ADDR_YEAR           4'h6
`define ADDR_CONTROL        4'h7
`define ADDR_CHARGER        4'h8
`define ADDR_FLAG           4'h9
`define CTRL_LEVEL_BIT      7
`define CTRL_FTEST_BIT      6
`define CTRL_SIGN_BIT       5
`define SEC_OSC_OFF_BIT     7
`define FLAG_OSF_BIT        7
`define CTRL_RESET          8'h80
`define CHARGER_RESET       8'h00
`define OSC_OFF_RESET       1'b0
`define CHARGER_KEY         4'hA
`define OSC_HZ              32768
`define SYS_HZ              20000000
`define TEST_HZ             512
`define TICK_DIV            (`SYS_HZ / `OSC_HZ)
`define TEST_HALF_TICKS     (`OSC_HZ / (2 * `TEST_HZ))
`define STAGE_TICKS         256
`define BLANK_TICKS         128
`define INSERT_TICKS        256
`define SEC_STAGES          (`OSC_HZ / `STAGE_TICKS)
`define CAL_CYCLE_MIN       64
`define CAL_ACTIVE_MIN      62
`define SEC_PER_MIN         60
`endif

// ===== shared/rtc_special_pkg.sv
package rtc_special_pkg;
  typedef struct packed {
    logic       level;
    logic       ftest;
    logic       sign;
    logic [4:0] magnitude;
  } control_s;
  typedef struct packed {
    logic [3:0] charger_enable_key;
    logic [1:0] diode_select;
    logic [1:0] resistor_select;
  } charger_s;
  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_250  = 2'h1,
    RES_2K   = 2'h2,
    RES_4K   = 2'h3
  } resistor_e;
  typedef struct packed {
    logic      enable;
    logic      diode;
    resistor_e resistor;
  } charge_path_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// ===== logic/rtc_special.sv
// Functional notes
// RULE1: With frequency test off, the output pin follows the static level bit.
// RULE2: The static level bit powers up as 1, output starts high.
// RULE3: Frequency test bit makes the pin toggle at 512Hz; powers up 0.
// RULE4: Sign bit 1 means positive calibration, 0 negative; powers up 0.
// RULE5: Five-bit calibration magnitude 0 to 31, powers up zero.
// RULE6: Charger enabled only when the key nibble equals 1010.
// RULE7: Charger register cleared at power-up, charger off.
// RULE8: Diode select 01 no diode, 10 one diode, 00 and 11 disable.
// RULE9: Resistor select 01 250 ohm, 10 2k, 11 4k, 00 disables.
// RULE10: Stop flag set on the running-to-stopped edge of the oscillator.
// RULE11: Stop flag set at power-up and when software disables the oscillator.
// RULE12: Stop flag stays set until written 0; writing 1 changes nothing.
// RULE13: Low seven flag bits read zero and ignore writes.
// RULE14: Calibration inserts or removes counts at the divide-by-256 stage.
// RULE15: Calibration cycle lasts 64 minutes; only first 62 minutes may correct.
// RULE16: Negative blanks 128 cycles, positive inserts 256 cycles per correction; code inserts 255 on positive.
// RULE17: Magnitude N corrects the first 2N minutes of each cycle.
// RULE18: Calibration leaves the test output frequency untouched.
// RULE19: Any control register write resets the divider chain.
// RULE20: Timekeeping registers have no assumed reset value.
// RULE21: Seconds top bit disables the oscillator when 1; powers up 0.
// RULE22: Pointer wraps 07h to 00h in bursts, and after 09h back to 00h.
// RULE23: The 512Hz test tone comes from the uncalibrated divider chain.
`timescale 1ns/100ps
`include "rtc_special_regs.svh"
module rtc_special (
  input  wire logic                        core_clk_in,
  input  wire logic                        arst_n_in,
  input  wire rtc_special_pkg::reg_req_s   req_in,
  input  wire logic                        ptr_load_in,
  input  wire logic                        ptr_step_in,
  input  wire logic                        osc_fail_in,
  output logic [7:0]                       rdata_out,
  output logic [3:0]                       ptr_out,
  output logic                             test_output_pin_out,
  output rtc_special_pkg::charge_path_s    charge_path_out,
  output logic                             osc_running_out,
  output logic                             second_tick_out
);
  import rtc_special_pkg::*;

  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    if (p == `ADDR_CONTROL || p == `ADDR_FLAG) begin
      next_ptr = 4'h0; // RULE22
    end else begin
      next_ptr = p + 4'h1;
    end
  endfunction

  control_s   ctrl_q;
  charger_s   chg_q;
  logic       osf_q;
  logic [7:0] time_q [0:6];
  logic [3:0] ptr_q;
  logic [9:0] tick_cnt_q;
  logic [4:0] tone_cnt_q;
  logic       osc_off_q;
  logic       tone_q;
  logic [8:0] stage_cnt_q;
  logic [6:0] stage_idx_q;
  logic [5:0] sec_q;
  logic [5:0] min_q;
  logic       run_q;
  logic       sec_tick_q;

  wire        wr_ctrl    = req_in.wr && (req_in.addr == `ADDR_CONTROL);
  wire        wr_chg     = req_in.wr && (req_in.addr == `ADDR_CHARGER);
  wire        wr_flag    = req_in.wr && (req_in.addr == `ADDR_FLAG);
  wire        wr_time    = req_in.wr && (req_in.addr < `ADDR_CONTROL);
  wire        wr_sec     = req_in.wr && (req_in.addr == `ADDR_SECONDS);
  wire        osc_off    = osc_off_q; // RULE21
  wire        running    = !osc_off && !osc_fail_in;
  wire        osc_tick   = running && (tick_cnt_q == 10'(`TICK_DIV - 1));
  wire        div_reset  = wr_ctrl || wr_sec; // RULE19

  // Correction applies in the first second of each of the first 2N minutes.
  wire [6:0]  cal_minutes = {1'b0, ctrl_q.magnitude, 1'b0}; // RULE17
  wire        cal_window  = (sec_q == 6'h00) && ({1'b0, min_q} < cal_minutes) &&
                            (min_q < 6'(`CAL_ACTIVE_MIN)); // RULE15
  // Negative: stage period of 128 extra ticks once, blanking them. Positive:
  // one stage finishes after a single tick, which counts 255 ticks extra.
  wire [8:0]  stage_len   = (cal_window && stage_idx_q == 7'h00) ?
                            (ctrl_q.sign ? 9'h001 :
                             9'(`STAGE_TICKS + `BLANK_TICKS)) :
                            9'(`STAGE_TICKS); // RULE4 RULE14 RULE16
  wire        stage_done  = osc_tick && (stage_cnt_q >= stage_len - 9'h001);
  wire        sec_done    = stage_done && (stage_idx_q == 7'(`SEC_STAGES - 1));

  wire        key_ok   = chg_q.charger_enable_key == `CHARGER_KEY; // RULE6
  wire        diode_ok = chg_q.diode_select == 2'h1 || chg_q.diode_select == 2'h2; // RULE8
  wire        res_ok   = chg_q.resistor_select != 2'h0; // RULE9

  wire [7:0]  rd_word =
    (req_in.addr == `ADDR_CONTROL) ? ctrl_q :
    (req_in.addr == `ADDR_CHARGER) ? chg_q :
    (req_in.addr == `ADDR_FLAG)    ? {osf_q, 7'h00} : // RULE13
    (req_in.addr == `ADDR_SECONDS) ? {osc_off_q, time_q[0][6:0]} : // RULE21
    (req_in.addr < `ADDR_CONTROL)  ? time_q[req_in.addr[2:0]] : 8'h00;

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= `CTRL_RESET; // RULE2 RULE3 RULE4 RULE5
    end else if (wr_ctrl) begin
      ctrl_q <= req_in.wdata;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      chg_q <= `CHARGER_RESET; // RULE7
    end else if (wr_chg) begin
      chg_q <= req_in.wdata;
    end
  end

  // Set wins over a simultaneous clear so a stop event is never lost.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osf_q <= 1'b1; // RULE11
    end else if (run_q && !running) begin
      osf_q <= 1'b1; // RULE10 RULE11
    end else if (wr_flag && !req_in.wdata[`FLAG_OSF_BIT]) begin
      osf_q <= 1'b0; // RULE12
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_q <= 1'b0;
    end else begin
      run_q <= running;
    end
  end

  // The oscillator disable bit is the one timekeeping bit with a power-up value.
  // Keeping it in its own flop means the oscillator state is known right after reset.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_off_q <= `OSC_OFF_RESET; // RULE21
    end else if (wr_sec) begin
      osc_off_q <= req_in.wdata[`SEC_OSC_OFF_BIT]; // RULE11 RULE21
    end
  end

  // Timekeeping bytes carry no reset apart from the oscillator disable bit.
  always_ff @(posedge core_clk_in) begin
    if (wr_time) begin
      time_q[req_in.addr[2:0]] <= req_in.wdata; // RULE20
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ptr_q <= 4'h0;
    end else if (ptr_load_in) begin
      ptr_q <= req_in.addr;
    end else if (ptr_step_in) begin
      ptr_q <= next_ptr(ptr_q); // RULE22
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 8'h00;
    end else if (req_in.rd) begin
      rdata_out <= rd_word;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_q <= 10'h000;
    end else if (!running || osc_tick) begin
      tick_cnt_q <= 10'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 10'h001;
    end
  end

  // Test tone is taken from the raw tick count, ahead of calibration.
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tone_cnt_q <= 5'h00;
      tone_q     <= 1'b0;
    end else if (div_reset) begin
      tone_cnt_q <= 5'h00; // RULE19
      tone_q     <= 1'b0;
    end else if (osc_tick) begin
      if (tone_cnt_q == 5'(`TEST_HALF_TICKS - 1)) begin
        tone_cnt_q <= 5'h00;
        tone_q     <= !tone_q; // RULE3 RULE18 RULE23
      end else begin
        tone_cnt_q <= tone_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      stage_cnt_q <= 9'h000;
      stage_idx_q <= 7'h00;
    end else if (div_reset) begin
      stage_cnt_q <= 9'h000; // RULE19
      stage_idx_q <= 7'h00;
    end else if (stage_done) begin
      stage_cnt_q <= 9'h000;
      stage_idx_q <= sec_done ? 7'h00 : stage_idx_q + 7'h01;
    end else if (osc_tick) begin
      stage_cnt_q <= stage_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_q <= 6'h00;
      min_q <= 6'h00;
    end else if (sec_done) begin
      if (sec_q == 6'(`SEC_PER_MIN - 1)) begin
        sec_q <= 6'h00;
        min_q <= (min_q == 6'(`CAL_CYCLE_MIN - 1)) ? 6'h00 : min_q + 6'h01; // RULE15
      end else begin
        sec_q <= sec_q + 6'h01;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= sec_done && !div_reset;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      test_output_pin_out <= 1'b1;
    end else begin
      test_output_pin_out <= ctrl_q.ftest ? tone_q : ctrl_q.level; // RULE1 RULE3
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      charge_path_out <= '0;
    end else begin
      charge_path_out.enable   <= key_ok && diode_ok && res_ok; // RULE6 RULE8 RULE9
      charge_path_out.diode    <= chg_q.diode_select == 2'h2; // RULE8
      charge_path_out.resistor <= resistor_e'(chg_q.resistor_select); // RULE9
    end
  end

  assign ptr_out         = ptr_q;
  assign osc_running_out = run_q;
  assign second_tick_out = sec_tick_q;
endmodule // rtc_special

// ===== sim/rtc_special_props.sv
`timescale 1ns/100ps
module rtc_special_props (
  input wire logic                          core_clk_in,
  input wire logic                          arst_n_in,
  input wire rtc_special_pkg::reg_req_s     req_in,
  input wire logic                          ptr_load_in,
  input wire logic                          ptr_step_in,
  input wire logic                          osc_fail_in,
  input wire logic [7:0]                    rdata_out,
  input wire logic [3:0]                    ptr_out,
  input wire logic                          test_output_pin_out,
  input wire logic                          osc_running_out,
  input wire rtc_special_pkg::charge_path_s charge_path_out
);
  import rtc_special_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence s_level_wr; req_in.wr && req_in.addr == 4'h7 && !req_in.wdata[6]; endsequence
  sequence s_chg_wr; req_in.wr && req_in.addr == 4'h8; endsequence
  chk_pin_level: assert property (s_level_wr |-> ##2
    test_output_pin_out == $past(req_in.wdata[7], 2)) else $error("pin level wrong");
  chk_chg_enable: assert property (s_chg_wr |-> ##2 charge_path_out.enable ==
    ($past(req_in.wdata[7:4], 2) == 4'hA && $past(req_in.wdata[3:2], 2) inside {2'h1, 2'h2}
    && $past(req_in.wdata[1:0], 2) != 2'h0)) else $error("charger enable wrong");
  chk_chg_path: assert property (s_chg_wr ##2 charge_path_out.enable |->
    {charge_path_out.diode, charge_path_out.resistor} ==
    {$past(req_in.wdata[3], 2), $past(req_in.wdata[1:0], 2)}) else $error("charger path wrong");
  chk_flag_low: assert property (req_in.rd && req_in.addr == 4'h9 |=> rdata_out[6:0] == 7'h00)
    else $error("flag low bits set");
  chk_ptr_wrap: assert property (ptr_step_in && !ptr_load_in && ptr_out inside {4'h7, 4'h9}
    |=> ptr_out == 4'h0) else $error("pointer did not wrap");
  chk_ptr_step: assert property (ptr_step_in && !ptr_load_in && !(ptr_out inside {4'h7, 4'h9})
    |=> ptr_out == $past(ptr_out) + 4'h1) else $error("pointer step wrong");
  chk_ptr_load: assert property (ptr_load_in |=> ptr_out == $past(req_in.addr))
    else $error("pointer load wrong");
  chk_rdata_hold: assert property (!req_in.rd |=> $stable(rdata_out)) else $error("read data moved");
  chk_osc_fail: assert property (osc_fail_in [*2] |-> !osc_running_out)
    else $error("oscillator runs while failed");
endmodule // rtc_special_props
bind rtc_special rtc_special_props i_props (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
  .req_in(req_in), .ptr_load_in(ptr_load_in), .ptr_step_in(ptr_step_in), .osc_fail_in(osc_fail_in),
  .rdata_out(rdata_out), .ptr_out(ptr_out), .test_output_pin_out(test_output_pin_out),
  .osc_running_out(osc_running_out), .charge_path_out(charge_path_out));

// ===== sim/host_model.sv
`timescale 1ns/100ps
module host_model (
  input  wire logic                      clk_in,
  input  wire logic [7:0]                rdata_in,
  output rtc_special_pkg::reg_req_s      req_out,
  output logic                           ptr_load_out,
  output logic                           ptr_step_out
);
  import rtc_special_pkg::*;
  initial req_out = '0;
  initial ptr_load_out = 1'b0;
  initial ptr_step_out = 1'b0;
  // Idle address lines show the inverse of the last value; data lines do too after wr and rd, but ptr leaves wdata unchanged.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(posedge clk_in);
    req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    @(posedge clk_in);
    d = rdata_in;
  endtask
  task automatic ptr(input logic ld, input logic [3:0] a);
    @(posedge clk_in);
    ptr_load_out <= ld;
    ptr_step_out <= !ld;
    req_out.addr <= a;
    @(posedge clk_in);
    ptr_load_out <= 1'b0;
    ptr_step_out <= 1'b0;
    req_out.addr <= ~a;
  endtask
endmodule // host_model

// ===== sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rtc_special_pkg::*;
  logic         core_clk_in, arst_n_in, osc_fail_in, ptr_load_in, ptr_step_in;
  logic         test_output_pin_out, osc_running_out;
  reg_req_s     req_in;
  charge_path_s charge_path_out;
  logic [7:0]   rdata_out, v;
  logic [3:0]   ptr_out;
  int           fail_count = 0;
  int           checks_done = 0;
  rtc_special i_rtc_special (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .req_in(req_in),
    .ptr_load_in(ptr_load_in), .ptr_step_in(ptr_step_in), .osc_fail_in(osc_fail_in),
    .rdata_out(rdata_out), .ptr_out(ptr_out), .test_output_pin_out(test_output_pin_out),
    .charge_path_out(charge_path_out), .osc_running_out(osc_running_out), .second_tick_out());
  host_model u_host (.clk_in(core_clk_in), .rdata_in(rdata_out), .req_out(req_in),
    .ptr_load_out(ptr_load_in), .ptr_step_out(ptr_step_in));
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(string name, logic [3:0] a, logic [7:0] exp);
    u_host.rd(a, v);
    check(name, v, exp);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    check("pin", test_output_pin_out, 1'b1);
    check("path", charge_path_out, 4'h0);
    rchk("ctrl", 4'h7, 8'h80);
    rchk("chg", 4'h8, 8'h00);
    rchk("flag", 4'h9, 8'h80);
    u_host.rd(4'h0, v);
    check("osc_off", v[7], 1'b0);
    check("run", osc_running_out, 1'b1);
    u_host.wr(4'h0, 8'h00);
  endtask
  task automatic t_level();
    logic [7:0] vals[3] = '{8'h1F, 8'hA0, 8'h00};
    foreach (vals[i]) begin
      u_host.wr(4'h7, vals[i]);
      repeat (2) @(posedge core_clk_in);
      #1;
      check("pin", test_output_pin_out, vals[i][7]);
      rchk("ctrl", 4'h7, vals[i]);
    end
  endtask
  task automatic t_charger();
    logic [7:0] cv[6] = '{8'hA5, 8'hAA, 8'hA7, 8'hA0, 8'hAD, 8'h55};
    logic       en;
    foreach (cv[i]) begin
      u_host.wr(4'h8, cv[i]);
      rchk("chg", 4'h8, cv[i]);
      en = cv[i][7:4] == 4'hA && cv[i][3:2] inside {2'h1, 2'h2} && cv[i][1:0] != 2'h0;
      check("chg_en", charge_path_out.enable, en);
      if (en)
        check("chg_sel", charge_path_out[2:0], {cv[i][3], cv[i][1:0]});
    end
  endtask
  task automatic t_flag();
    u_host.wr(4'h9, 8'hFF);
    rchk("flag", 4'h9, 8'h80);
    u_host.wr(4'h9, 8'h00);
    rchk("flag", 4'h9, 8'h00);
    u_host.wr(4'h0, 8'h80);
    rchk("flag", 4'h9, 8'h80);
    check("run", osc_running_out, 1'b0);
    u_host.wr(4'h0, 8'h00);
    u_host.wr(4'h9, 8'h00);
    osc_fail_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    check("run", osc_running_out, 1'b0);
    osc_fail_in <= 1'b0;
    rchk("flag", 4'h9, 8'h80);
  endtask
  task automatic t_ptr();
    logic [4:0] ops[6] = '{5'h16, 5'h00, 5'h00, 5'h18, 5'h00, 5'h00};
    logic [3:0] exp[6] = '{4'h6, 4'h7, 4'h0, 4'h8, 4'h9, 4'h0};
    foreach (ops[i]) begin
      u_host.ptr(ops[i][4], ops[i][3:0]);
      #1;
      check("ptr", ptr_out, exp[i]);
    end
    u_host.wr(4'hB, 8'h12);
    rchk("unmapped", 4'hA, 8'h00);
  endtask
  task automatic t_tone();
    int n;
    u_host.wr(4'h7, 8'h7F);
    @(test_output_pin_out);
    n = 0;
    v[0] = test_output_pin_out;
    while (test_output_pin_out === v[0] && n < 40000) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check("half_period", n, 32 * 610);
  endtask
  initial begin
    arst_n_in = 1'b0;
    osc_fail_in = 1'b0;
    repeat (16) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_level();
    t_charger();
    t_flag();
    t_ptr();
    t_tone();
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge core_clk_in);
    fail_count++;
    give_verdict();
  end
endmodule // tb_top
